// *** common/bp_if.sv ***
// Backplane data transfer lines joining master and slave ends
`timescale 1ns/1ps
interface bp_if;
  import bp_pkg::*;
  logic            ds_n;          // Data strobe, low active
  logic            write_n;       // Low for a write
  logic [AM_W-1:0] am;            // Address modifier
  logic [AD_W-1:0] addr;          // Address
  logic [DW-1:0]   wdata;         // Master write data
  logic [DW-1:0]   rdata;         // Slave read data
  logic            dtack_n_o;     // Acknowledge driven level
  logic            dtack_oe;      // Acknowledge enable
  logic            berr_n_o;      // Error driven level
  logic            berr_oe;       // Error enable
  logic            retry_n_o;     // Retry driven level
  logic            retry_oe;      // Retry enable
  logic            timer_berr_n;  // Bus timer error, low active
  logic            slv_breq;      // Slave's own bus request
  logic            bg_in_n;       // Grant chain into slave
  logic            bg_out_n;      // Grant chain out of slave
  logic            iack_in_n;     // Ack chain into slave
  logic            iack_out_n;    // Ack chain out of slave

  // Wired levels of the open-collector lines, pulled high when idle
  logic dtack_n;
  logic berr_n;
  logic retry_n;
  assign dtack_n = dtack_oe ? dtack_n_o : 1'b1;
  assign berr_n  = (berr_oe ? berr_n_o : 1'b1) & timer_berr_n;
  assign retry_n = retry_oe ? retry_n_o : 1'b1;

  modport slave (
    input  ds_n, write_n, am, addr, wdata, bg_in_n, iack_in_n,
    output rdata, dtack_n_o, dtack_oe, berr_n_o, berr_oe,
    output retry_n_o, retry_oe, slv_breq, bg_out_n, iack_out_n
  );
  modport master (
    output ds_n, write_n, am, addr, wdata, timer_berr_n, bg_in_n,
    output iack_in_n,
    input  rdata, dtack_n, berr_n, retry_n, slv_breq
  );
endinterface : bp_if

// *** common/bp_pkg.sv ***
// Shared constants and a modifier check for the backplane slave termination block
package bp_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_PERIOD_NS    = 25;        // 40 MHz system clock
  localparam int ACK_MAX_NS       = 100;       // Fast acknowledge limit
  localparam int WAIT_MAX_US      = 20;        // Busy hold limit
  localparam int RELEASE_MAX_NS   = 100;       // Preferred release limit
  localparam int BTO_MIN_US       = 100;       // Least bus timer interval
  localparam int ACK_MAX_CYC      = ACK_MAX_NS / CLK_PERIOD_NS;
  localparam int WAIT_MAX_CYC     = WAIT_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int RELEASE_MAX_CYC  = RELEASE_MAX_NS / CLK_PERIOD_NS;
  localparam int BTO_MIN_CYC      = (BTO_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
  localparam int RESCIND_CYC      = 1;         // Active-high drive time

  // ==========================================================
  // Bus widths
  // ==========================================================
  localparam int AM_W = 6;                     // Address modifier width
  localparam int AD_W = 32;                    // Address width
  localparam int DW   = 32;                    // Data width
  localparam int TW   = 16;                    // Timer width

  // ==========================================================
  // Address modifier codes to avoid
  // ==========================================================
  localparam logic [5:0] AM_LOCK0   = 6'h04;
  localparam logic [5:0] AM_LOCK1   = 6'h05;
  localparam logic [5:0] AM_LOCK2   = 6'h2C;
  localparam logic [5:0] AM_LOCK3   = 6'h32;
  localparam logic [5:0] AM_LOCK4   = 6'h35;
  localparam logic [5:0] AM_USER_LO = 6'h10;
  localparam logic [5:0] AM_USER_HI = 6'h1F;
  localparam logic [5:0] AM_CFG     = 6'h2F;
  localparam logic [5:0] AM_A40_0   = 6'h34;
  localparam logic [5:0] AM_A40_1   = 6'h37;
  localparam logic [5:0] AM_DE_0    = 6'h20;
  localparam logic [5:0] AM_DE_1    = 6'h21;

  // True for any modifier that neither end should use
  function automatic logic am_banned(input logic [5:0] am);
    am_banned = (am == AM_LOCK0) || (am == AM_LOCK1) || (am == AM_LOCK2)
             || (am == AM_LOCK3) || (am == AM_LOCK4) || (am == AM_CFG)
             || (am >= AM_USER_LO && am <= AM_USER_HI)
             || (am == AM_A40_0) || (am == AM_A40_1)
             || (am == AM_DE_0) || (am == AM_DE_1);
  endfunction : am_banned

endpackage : bp_pkg

// *** sim/backplane_slave_cycle_termination_test.sv ***
// Bench joining master and slave ends, checked against a bench model
`timescale 1ns/1ps
module backplane_slave_cycle_termination_test;
  import bp_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  localparam int BTO_SIM  = 20;          // Short bus timer
  localparam int WAIT_SIM = 10;          // Short busy hold
  logic            clk, rst, req, req_wr, busy, done;
  logic [AM_W-1:0] req_am;
  logic [AD_W-1:0] req_addr, reg_addr;
  logic [DW-1:0]   req_wdata, rdata, reg_rdata, reg_wdata, wr_data;
  logic [3:0]      breq, grant;
  logic [1:0]      status;
  logic            retry_ok, reg_ready, own_breq, use_bg;
  logic            reg_wr, reg_rd, bus_owned, wr_seen, rd_seen;
  logic [AD_W-1:0] ad_seen;              // Address seen at a strobe
  logic [31:0]     lfsr;                 // Random source
  int              err_total, n_compared, rdy_after, low_cnt;
  logic [5:0] avoid_am [12] = '{6'h04, 6'h05, 6'h2C, 6'h32, 6'h35,
    6'h10, 6'h1F, 6'h2F, 6'h34, 6'h37, 6'h20, 6'h21};
  logic [5:0] ok_am [4] = '{6'h09, 6'h0D, 6'h39, 6'h3D};

  bp_if bp_if_i ();
  bp_master_end #(.BTO_CYC(BTO_SIM)) bp_master_end_i (.clk(clk),
    .rst(rst), .req(req), .req_wr(req_wr), .req_am(req_am),
    .req_addr(req_addr), .req_wdata(req_wdata), .breq(breq),
    .busy(busy), .done(done), .status(status), .rdata(rdata),
    .grant(grant), .bus(bp_if_i.master));
  bp_slave_end #(.WAIT_CYC(WAIT_SIM)) bp_slave_end_i (.clk(clk),
    .rst(rst), .retry_ok(retry_ok), .reg_ready(reg_ready),
    .reg_rdata(reg_rdata), .own_breq(own_breq), .use_bg(use_bg),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .bus_owned(bus_owned), .bus(bp_if_i.slave));
  bp_props #(.WAIT_CYC(WAIT_SIM), .BTO_CYC(BTO_SIM)) bp_props_i (
    .clk(clk), .rst(rst), .ds_n(bp_if_i.ds_n), .am(bp_if_i.am),
    .addr(bp_if_i.addr), .dtack_n_o(bp_if_i.dtack_n_o),
    .dtack_oe(bp_if_i.dtack_oe), .berr_oe(bp_if_i.berr_oe),
    .retry_n_o(bp_if_i.retry_n_o), .retry_oe(bp_if_i.retry_oe),
    .dtack_n(bp_if_i.dtack_n), .berr_n(bp_if_i.berr_n),
    .retry_n(bp_if_i.retry_n), .timer_berr_n(bp_if_i.timer_berr_n),
    .slv_breq(bp_if_i.slv_breq), .bg_in_n(bp_if_i.bg_in_n),
    .bg_out_n(bp_if_i.bg_out_n), .iack_in_n(bp_if_i.iack_in_n),
    .iack_out_n(bp_if_i.iack_out_n));

  // Clock of 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Register turns ready after rdy_after strobe cycles, never if negative
  always @(posedge clk) begin
    low_cnt <= bp_if_i.ds_n ? 0 : low_cnt + 1;
    reg_ready <= (rdy_after == 0) || (rdy_after > 0 && !bp_if_i.ds_n
                 && low_cnt + 1 >= rdy_after);
    if (reg_wr === 1'b1) begin
      wr_seen = 1'b1;
      wr_data = reg_wdata;
    end
    if (reg_rd === 1'b1) rd_seen = 1'b1;
    if ((reg_wr | reg_rd) === 1'b1) ad_seen = reg_addr;
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : step

  // Expected status: 0 ack, 1 error, 2 retry, 3 refused modifier
  function automatic int model(input logic [5:0] am,
      input logic [31:0] ad, input int ra, input logic rok);
    if (am >= 6'h10 && am <= 6'h1F) return 3;
    foreach (avoid_am[i]) if (am == avoid_am[i]) return 3;
    if (ad[31:8] != 24'h0) return 1;
    if (ra == 0) return 0;
    if (rok) return 2;
    return (ra > 0 && ra <= WAIT_SIM) ? 0 : 1;
  endfunction : model

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic end_of_test();
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // One access; answer latency from strobe, total cycles to done
  task automatic run(input logic wr, input logic [5:0] am,
      input logic [31:0] ad, input int ra, input logic rok);
    int cyc, t0, ta, te, es;
    cyc = 0; t0 = -1; ta = -1; te = -1;
    es = model(am, ad, ra, rok);
    rdy_after = ra;
    wr_seen = 1'b0;
    rd_seen = 1'b0;
    lfsr = step(lfsr);
    @(posedge clk);
    retry_ok <= rok;
    reg_rdata <= ~lfsr;
    req <= 1'b1; req_wr <= wr; req_am <= am; req_addr <= ad;
    req_wdata <= lfsr;
    @(posedge clk);
    req <= 1'b0;
    while (te < 0 && cyc < 400) begin
      @(negedge clk);
      cyc++;
      if (t0 < 0 && bp_if_i.ds_n === 1'b0) t0 = cyc;
      if (t0 >= 0 && ta < 0 && (bp_if_i.dtack_n & bp_if_i.berr_n
          & bp_if_i.retry_n) === 1'b0) ta = cyc - t0;
      if (own_breq && es != 1 && t0 >= 0 && cyc > t0
          && bp_if_i.ds_n === 1'b0)
        chk(bp_if_i.slv_breq, 1'b0, "request kept");
      if (done === 1'b1) te = cyc;
    end
    chk(te > 0, 1'b1, "no done");
    chk(status, es[1:0], "status");
    if (es == 0 && ra == 0) chk(ta <= ACK_MAX_CYC, 1'b1, "late ack");
    if (es == 2) chk(ta <= ACK_MAX_CYC, 1'b1, "late retry");
    if (es == 1 && ad[31:8] == 24'h0)
      chk(ta <= WAIT_SIM + 2, 1'b1, "late error");
    if (es == 1 && ad[31:8] != 24'h0)
      chk(te >= BTO_SIM, 1'b1, "timer early");
    if (es == 3) chk(t0, -1, "strobe on refused access");
    if (es == 0 && wr) chk(wr_data, lfsr, "write data");
    if (es == 0 && !wr) chk(rdata, ~lfsr, "read data");
    if (es == 0 && wr) chk(wr_seen, 1'b1, "no write strobe");
    if (es == 0 && !wr) chk(rd_seen, 1'b1, "no read strobe");
    if (es == 0) chk(ad_seen, ad, "register address");
    repeat (2) @(posedge clk);
  endtask : run

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    rst = 1'b1; req = 1'b0; req_wr = 1'b0; req_am = 6'h09;
    req_addr = '0; req_wdata = '0; breq = 4'h0; retry_ok = 1'b0;
    reg_rdata = '0; own_breq = 1'b0; use_bg = 1'b0; reg_ready = 1'b0;
    lfsr = 32'h9601; err_total = 0; n_compared = 0; rdy_after = 0;
    low_cnt = 0; wr_seen = 1'b0; wr_data = '0;
    rd_seen = 1'b0; ad_seen = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Ready accesses at random offsets and modifiers
    for (int i = 0; i < 8; i++) begin
      lfsr = step(lfsr);
      run(lfsr[0], ok_am[lfsr[3:2]], {24'h0, lfsr[11:6], 2'b00}, 0, 0);
    end
    run(1'b0, 6'h0D, 32'h10, 5, 1'b1);
    run(1'b1, 6'h0D, 32'h14, 5, 1'b0);
    run(1'b0, 6'h0D, 32'h18, -1, 1'b0);
    // Slave wanting the bus yields to the current master
    own_breq <= 1'b1;
    repeat (2) @(negedge clk);
    chk(bp_if_i.slv_breq, 1'b1, "no own request");
    run(1'b1, 6'h39, 32'h20, 0, 1'b0);
    run(1'b0, 6'h39, 32'h24, -1, 1'b0);
    own_breq <= 1'b0;
    foreach (avoid_am[i]) run(1'b0, avoid_am[i], 32'h0, 0, 1'b0);
    run(1'b0, 6'h0D, 32'h0000_0100, 0, 1'b0);
    // Fixed priority over every request pattern
    for (int b = 0; b < 16; b++) begin
      breq <= b[3:0];
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(grant, (b == 0) ? 4'h0 : 4'h1 << $clog2(b + 1) - 1, "grant");
    end
    // Idle slave takes a grant it asked for, else passes it on
    own_breq <= 1'b1;
    use_bg <= 1'b1;
    breq <= 4'h1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(bus_owned, 1'b1, "grant not used");
    chk(bp_if_i.bg_out_n, 1'b1, "used grant passed");
    @(posedge clk);
    use_bg <= 1'b0;
    @(negedge clk);
    chk(bp_if_i.bg_out_n, 1'b0, "grant not passed");
    end_of_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end
endmodule : backplane_slave_cycle_termination_test

// *** sim/bp_props.sv ***
// Concurrent checks on the lines between the master and slave ends
`timescale 1ns/1ps
module bp_props
  import bp_pkg::*;
#(
  parameter int WAIT_CYC = WAIT_MAX_CYC, // Busy hold limit
  parameter int BTO_CYC  = BTO_MIN_CYC   // Bus timer interval
) (
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            ds_n,
  input wire logic [AM_W-1:0] am,
  input wire logic [AD_W-1:0] addr,
  input wire logic            dtack_n_o,
  input wire logic            dtack_oe,
  input wire logic            berr_oe,
  input wire logic            retry_n_o,
  input wire logic            retry_oe,
  input wire logic            dtack_n,
  input wire logic            berr_n,
  input wire logic            retry_n,
  input wire logic            timer_berr_n,
  input wire logic            slv_breq,
  input wire logic            bg_in_n,
  input wire logic            bg_out_n,
  input wire logic            iack_in_n,
  input wire logic            iack_out_n
);
  // ==========================================================
  // Helpers
  // ==========================================================
  localparam int ANS_MAX = WAIT_CYC + 2;   // Held answer plus slack
  localparam int REL_MAX = RELEASE_MAX_CYC; // Preferred release
  localparam int BTO_LOW = BTO_CYC - 2;    // Timer launch slack
  localparam int BTO_END = BTO_CYC + 4;    // Strobe may not outlive
  logic hit;                               // Access decoded by slave
  int   low_cnt;                           // Cycles strobe held low
  assign hit = (addr[AD_W-1:8] == '0) && !am_banned(am);

  // Count strobe-low cycles; a counter avoids long repetitions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= ds_n ? 0 : low_cnt + 1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Assertions
  // ==========================================================
  a_answer_in_time: assert property ($fell(ds_n) && hit
    |-> ##[1:ANS_MAX] (!dtack_n || !berr_n || !retry_n))
    else $error("no answer to decoded strobe");
  a_release_quick: assert property ($rose(ds_n)
    |-> ##[1:REL_MAX] (dtack_n && !berr_oe && !retry_oe))
    else $error("answer lines not released");
  a_rescind_high: assert property ($fell(dtack_oe)
    |-> $past(dtack_n_o)) else $error("ack released while low");
  a_rescind_short: assert property (dtack_oe && $rose(dtack_n_o)
    |=> !dtack_oe) else $error("ack driven high too long");
  a_legal_modifier: assert property ($fell(ds_n)
    |-> !am_banned(am)) else $error("strobe with avoided modifier");
  a_breq_yield: assert property (!ds_n && hit ##1 !ds_n
    |-> !slv_breq) else $error("slave kept its request");
  a_timer_patient: assert property ($fell(timer_berr_n)
    |-> low_cnt >= BTO_LOW) else $error("bus timer too early");
  a_timer_ends: assert property (low_cnt <= BTO_END)
    else $error("silent cycle never ended");
  a_one_answer: assert property (!(dtack_oe && !dtack_n_o
    && retry_oe && !retry_n_o)) else $error("ack and retry together");
  a_grant_chain: assert property ((bg_in_n || !slv_breq)
    |-> bg_out_n == bg_in_n) else $error("grant chain broken");
  a_iack_chain: assert property (iack_in_n ##1 iack_in_n
    |-> iack_out_n) else $error("iack made up by slave");

  cover property ($fell(ds_n) && hit ##1 !dtack_n);
  cover property ($fell(ds_n) && hit ##1 !retry_n);
  cover property ($fell(timer_berr_n));
endmodule : bp_props

// *** src/bp_master_end.sv ***
// Bus master end with bus timer, arbiter grant and chain sources
`timescale 1ns/1ps
module bp_master_end
  import bp_pkg::*;
#(
  parameter int BTO_CYC = BTO_MIN_CYC  // Bus timer interval in cycles
) (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            req,      // Start an access, pulse
  input  wire logic            req_wr,   // Access is a write
  input  wire logic [AM_W-1:0] req_am,   // Modifier for the access
  input  wire logic [AD_W-1:0] req_addr, // Address for the access
  input  wire logic [DW-1:0]   req_wdata,// Write data
  input  wire logic [3:0]      breq,     // Bus request levels
  output logic                 busy,     // Access in progress
  output logic                 done,     // Access ended, pulse
  output logic [1:0]           status,   // 0 ok, 1 error, 2 retry, 3 ref
  output logic [DW-1:0]        rdata,    // Read data
  output logic [3:0]           grant,    // One-hot grant by priority
  bp_if.master                 bus
);
  // ==========================================================
  // State
  // ==========================================================
  typedef enum logic [2:0] {
    M_IDLE = 3'b001,             // Waiting for a request
    M_WAIT = 3'b010,             // Strobe low, waiting for answer
    M_END  = 3'b100              // Strobe high, waiting for release
  } mst_t;
  typedef struct packed {
    mst_t            fsm;
    logic            ds_n;
    logic            wr;
    logic [AM_W-1:0] am;
    logic [AD_W-1:0] addr;
    logic [DW-1:0]   wdata;
    logic [DW-1:0]   rdata;
    logic [1:0]      status;
    logic            done;
    logic            tberr;      // Timer error drive
    logic [3:0]      grant;
  } mst_st_t;
  mst_st_t st_reg;               // Registered state
  mst_st_t st_next;              // Next state
  logic    bto_hit;              // Bus timer expiry

  // Bus timer runs while an access waits for an answer
  bp_timer #(.LIMIT(BTO_CYC)) u_bto (
    .clk     (clk),
    .rst     (rst),
    .run     (st_reg.fsm == M_WAIT),
    .expired (bto_hit)
  );

  // Sequence the access and arbitrate
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    // Fixed priority, level 3 highest
    st_next.grant = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (breq[i]) st_next.grant = 4'(1 << i);
    end
    // No grant goes out while the slave requests and an access is open
    if (bus.slv_breq && st_reg.fsm != M_IDLE) st_next.grant = 4'h0;
    case (st_reg.fsm)
      M_IDLE: begin
        // Banned modifiers are refused outright
        if (req && am_banned(req_am)) begin
          st_next.done   = 1'b1;
          st_next.status = 2'd3;
        end else if (req) begin
          st_next.ds_n  = 1'b0;
          st_next.wr    = req_wr;
          st_next.am    = req_am;
          st_next.addr  = req_addr;
          st_next.wdata = req_wdata;
          st_next.fsm   = M_WAIT;
        end
      end
      M_WAIT: begin
        if (!bus.dtack_n) begin
          st_next.status = 2'd0;
          st_next.rdata  = bus.rdata;
        end else if (!bus.berr_n) begin
          st_next.status = 2'd1;
        end else if (!bus.retry_n) begin
          st_next.status = 2'd2;
        end else if (bto_hit) begin
          st_next.tberr = 1'b1;              // Timer ends the cycle
        end
        if (!bus.dtack_n || !bus.berr_n || !bus.retry_n) begin
          st_next.ds_n  = 1'b1;
          st_next.tberr = 1'b0;
          st_next.fsm   = M_END;
        end
      end
      M_END: begin
        // Wait for every answer line to go high again
        if (bus.dtack_n && bus.berr_n && bus.retry_n) begin
          st_next.done = 1'b1;
          st_next.fsm  = M_IDLE;
        end
      end
      default: st_next = '{fsm: M_IDLE, ds_n: 1'b1, default: '0};
    endcase
  end

  // Register the state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{fsm: M_IDLE, ds_n: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign busy             = (st_reg.fsm != M_IDLE);
  assign done             = st_reg.done;
  assign status           = st_reg.status;
  assign rdata            = st_reg.rdata;
  assign grant            = st_reg.grant;
  assign bus.ds_n         = st_reg.ds_n;
  assign bus.write_n      = !st_reg.wr;
  assign bus.am           = st_reg.am;
  assign bus.addr         = st_reg.addr;
  assign bus.wdata        = st_reg.wdata;
  assign bus.timer_berr_n = !st_reg.tberr;
  assign bus.bg_in_n      = !(|st_reg.grant);
  assign bus.iack_in_n    = 1'b1;
endmodule : bp_master_end

// *** src/bp_slave_end.sv ***
// Slave end: answers accesses with acknowledge, retry or error
// Behaviour
// - Lock modifiers 04 05 2C 32 35 unused
// - User, config, A40, double-edge modifiers unused
// - Ready register acknowledges with no wait
// - Busy register signals retry
// - Without retry, hold busy; ack or error
// - Drop own bus request when addressed
// - Acknowledge within 100 ns of strobe
// - Retry within 100 ns of strobe
// - Ack or error within 20 us
// - Release lines within 5 us of strobe rise
// - Prefer release within 0.1 us
// - Drive acknowledge high briefly before release
// - Never depend on configuration ROM space
// - Bus timer waits at least 100 us
// - Pass or use the grant chain
// - Arbiter grants by fixed priority
// - Pass or use the acknowledge chain
`timescale 1ns/1ps
module bp_slave_end
  import bp_pkg::*;
#(
  parameter int          WAIT_CYC = WAIT_MAX_CYC, // Busy hold limit
  parameter logic [AD_W-1:0] BASE = 32'h0000_0000, // Decoded base
  parameter logic [AD_W-1:0] MASK = 32'hFFFF_FF00  // Decode mask
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          retry_ok,  // Both ends support retry
  input  wire logic          reg_ready, // User register can take part
  input  wire logic [DW-1:0] reg_rdata, // User register read data
  input  wire logic          own_breq,  // Slave wants the bus
  input  wire logic          use_bg,    // Slave consumes a grant
  output logic               reg_wr,    // Write strobe, pulse
  output logic               reg_rd,    // Read strobe, pulse
  output logic [AD_W-1:0]    reg_addr,  // Register address
  output logic [DW-1:0]      reg_wdata, // Register write data
  output logic               bus_owned, // Slave holds a grant
  bp_if.slave                bus
);
  // ==========================================================
  // State
  // ==========================================================
  typedef enum logic [4:0] {
    S_IDLE    = 5'b00001,        // No access
    S_HOLD    = 5'b00010,        // Busy, waiting for ready
    S_ANSWER  = 5'b00100,        // Answer driven low
    S_RESCIND = 5'b01000,        // Acknowledge driven high
    S_DONE    = 5'b10000         // Not entered by any transition
  } slv_t;
  typedef struct packed {
    slv_t            fsm;
    logic            dtack;      // Drive acknowledge low
    logic            berr;       // Drive error low
    logic            retry;      // Drive retry low
    logic            rescind;    // Drive acknowledge high
    logic            wr;
    logic            rd;
    logic [AD_W-1:0] addr;
    logic [DW-1:0]   wdata;
    logic [DW-1:0]   rdata;
  } slv_st_t;
  slv_st_t st_reg;               // Registered state
  slv_st_t st_next;              // Next state
  logic    hit;                  // Access is for this slave
  logic    wait_hit;             // Busy hold limit reached

  // Decode ignores the configuration ROM modifier entirely
  assign hit = !bus.ds_n && ((bus.addr & MASK) == BASE)
            && !am_banned(bus.am);

  // Times the busy hold; cleared when the hold ends
  bp_timer #(.LIMIT(WAIT_CYC)) u_wait (
    .clk     (clk),
    .rst     (rst),
    .run     (st_reg.fsm == S_HOLD),
    .expired (wait_hit)
  );

  // Answer sequencing
  always_comb begin
    st_next    = st_reg;
    st_next.wr = 1'b0;
    st_next.rd = 1'b0;
    case (st_reg.fsm)
      S_IDLE: begin
        if (hit) begin
          st_next.addr  = bus.addr;
          st_next.wdata = bus.wdata;
          if (reg_ready) begin
            // One cycle from strobe to acknowledge
            st_next.wr    = !bus.write_n;
            st_next.rd    = bus.write_n;
            st_next.rdata = reg_rdata;
            st_next.dtack = 1'b1;
            st_next.fsm   = S_ANSWER;
          end else if (retry_ok) begin
            st_next.retry = 1'b1;
            st_next.fsm   = S_ANSWER;
          end else begin
            st_next.fsm = S_HOLD;
          end
        end
      end
      S_HOLD: begin
        // Hold ends in ack once ready, in error once the limit is reached, or back in idle if the strobe rises
        if (bus.ds_n) begin
          st_next.fsm = S_IDLE;
        end else if (reg_ready) begin
          st_next.wr    = !bus.write_n;
          st_next.rd    = bus.write_n;
          st_next.rdata = reg_rdata;
          st_next.dtack = 1'b1;
          st_next.fsm   = S_ANSWER;
        end else if (wait_hit) begin
          st_next.berr = 1'b1;
          st_next.fsm  = S_ANSWER;
        end
      end
      S_ANSWER: begin
        // Release one cycle after strobe rises
        if (bus.ds_n) begin
          st_next.rescind = st_reg.dtack;
          st_next.dtack   = 1'b0;
          st_next.berr    = 1'b0;
          st_next.retry   = 1'b0;
          st_next.fsm     = st_reg.dtack ? S_RESCIND : S_IDLE;
        end
      end
      S_RESCIND: begin
        // High drive lasts RESCIND_CYC cycle, then let go
        st_next.rescind = 1'b0;
        st_next.fsm     = S_IDLE;
      end
      default: st_next = '{fsm: S_IDLE, default: '0};
    endcase
  end

  // Register the state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{fsm: S_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Open-collector answers
  // ==========================================================
  assign bus.dtack_n_o = !st_reg.dtack;
  assign bus.dtack_oe  = st_reg.dtack | st_reg.rescind;
  assign bus.berr_n_o  = 1'b0;
  assign bus.berr_oe   = st_reg.berr;
  assign bus.retry_n_o = 1'b0;
  assign bus.retry_oe  = st_reg.retry;
  assign bus.rdata     = st_reg.rdata;

  // Own request withdrawn while an access to us is open
  assign bus.slv_breq = own_breq && (st_reg.fsm == S_IDLE) && !hit;

  // Grant used only when we asked, else passed on
  assign bus_owned    = use_bg && bus.slv_breq && !bus.bg_in_n;
  assign bus.bg_out_n = bus.bg_in_n | (use_bg & bus.slv_breq);
  // No interrupter here, so the chain passes straight
  assign bus.iack_out_n = bus.iack_in_n;

  assign reg_wr    = st_reg.wr;
  assign reg_rd    = st_reg.rd;
  assign reg_addr  = st_reg.addr;
  assign reg_wdata = st_reg.wdata;
endmodule : bp_slave_end

// *** src/bp_timer.sv ***
// Up-counting timer shared by the slave wait and the master bus timer
`timescale 1ns/1ps
module bp_timer
  import bp_pkg::*;
#(
  parameter int LIMIT = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      expired
);
  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [TW-1:0] cnt;          // Cycles run so far
    logic          done;         // Limit reached
  } tmr_t;
  tmr_t st_reg;                  // Registered state
  tmr_t st_next;                 // Next state

  // Count while run is high, clear as soon as it drops
  always_comb begin
    st_next = st_reg;
    if (!run) begin
      st_next.cnt  = '0;
      st_next.done = 1'b0;
    end else if (!st_reg.done) begin
      st_next.cnt = st_reg.cnt + 1'b1;
      // Done flags at the LIMIT-th cycle of run
      st_next.done = (st_reg.cnt == TW'(LIMIT - 2));
    end
  end

  // Register the state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expired = st_reg.done;
endmodule : bp_timer
